// ==== logic/port_consts.svh ====
// Purpose: named constants for the port C / port E pin block
// Assumes: register index times four is the byte address
// Notes: definitions only
`ifndef PORT_CONSTS_SVH
`define PORT_CONSTS_SVH

`define ADDR_W          12
`define IDX_LSB         2
`define IDX_MSB         9
`define IDX_PORT_C_DATA 8'h07
`define IDX_PORT_D_DATA 8'h08
`define IDX_PORT_E_DATA 8'h09
`define IDX_PORT_C_DIR  8'h87
`define IDX_PORT_E_DIR  8'h89
`define IDX_ANALOG_CFG  8'h9F

`define PC_DIR_RST      8'hFF
`define PE_DIR_RST      3'h7
`define PCFG_RST        3'h0
`define LAT_COLD8       8'h00
`define LAT_COLD3       3'h0
`define ANALOG_LIMIT    3'h4

`define BIT_IBF         7
`define BIT_OBF         6
`define BIT_INPUT_OVERFLOW_FLAG        5
`define BIT_PSP         4

`define PIN_RD          0
`define PIN_WR          1
`define PIN_CS          2

`define PIN_TIMER1_CLK  0
`define PIN_TIMER1_OSC  1
`define PIN_CAPTURE_COMPARE_PWM_2        1
`define PIN_CAPTURE_COMPARE_PWM_1        2
`define PIN_SER_CLK     3
`define PIN_SER_DIN     4
`define PIN_USART_CLK   6
`define PIN_USART_DATA  7

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define ALL_OFF8        8'hFF
`define ALL_ON8         8'h00

`endif

// ==== logic/port_pkg.sv ====
// Purpose: carrier and state types for the port C / port E pin block
// Assumes: constants header is on the include path
// Notes: types only
`include "port_consts.svh"
package port_pkg;

  typedef struct packed {
    logic               awvalid;
    logic [`ADDR_W-1:0] awaddr;
    logic               wvalid;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bready;
    logic               arvalid;
    logic [`ADDR_W-1:0] araddr;
    logic               rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] oe;
    logic [7:0] out;
  } periph_req_t;

  typedef struct packed {
    logic timer1_clock_in;
    logic timer1_osc_in;
    logic capture_compare_pwm_2_in;
    logic capture_compare_pwm_1_in;
    logic serial_clock_in;
    logic serial_data_in;
    logic usart_clock_in;
    logic usart_data_in;
  } periph_lvl_t;

  typedef struct packed {
    logic [7:0]         pc_lat, pc_dir, pc_s1, pc_s2, pc_s3, pc_lvl, pc_out, pc_oe_n;
    logic [2:0]         pe_lat, pe_dir, pe_s1, pe_s2, pe_s3, pe_lvl, pe_out, pe_oe_n;
    logic [2:0]         pe_ana, pcfg;
    logic [7:0]         pd_olat, pd_ilat, pd_s1, pd_s2, pd_s3, pd_lvl, pd_out, pd_oe_n;
    logic               psp_en, input_full_flag, output_full_flag, input_overflow_flag, wr_act;
    logic [`ADDR_W-1:0] aw_addr;
    logic               aw_hold, w_hold, w_stb;
    logic [7:0]         wdata, rdata;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [1:0]         bresp, rresp;
  } state_t;

endpackage : port_pkg

// ==== logic/port_c_e_pin_control.sv ====
// Purpose: port C and port E pins, parallel slave strobes, AXI4-Lite registers
// Assumes: pins are asynchronous; peripheral requests share mclk
// Notes: pin drives lag the registers by one cycle
`timescale 1ns/1ps
`default_nettype none
`include "port_consts.svh"

module port_c_e_pin_control (
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic                  cold_rst,
  input  wire logic                  ce,
  input  wire port_pkg::axi_req_t    axi_req,
  output var  port_pkg::axi_rsp_t    axi_rsp,
  input  wire port_pkg::periph_req_t pc_periph,
  output var  port_pkg::periph_lvl_t pc_levels,
  input  wire logic [7:0]            pc_in,
  output logic [7:0]                 pc_out,
  output logic [7:0]                 pc_oe_n,
  input  wire logic [2:0]            pe_in,
  output logic [2:0]                 pe_out,
  output logic [2:0]                 pe_oe_n,
  output logic [2:0]                 pe_analog_sel,
  input  wire logic [7:0]            pd_in,
  output logic [7:0]                 pd_out,
  output logic [7:0]                 pd_oe_n
);

  port_pkg::state_t st_ff;
  port_pkg::state_t nxt_st;

  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       do_wr;
  logic       rd_act;
  logic       wr_act;
  logic       wr_end;
  logic [7:0] wd;
  logic [7:0] drv;
  logic [7:0] pe_f;

  // new level counts only once stages two and three agree
  function automatic logic [7:0] filt(input logic [7:0] old, input logic [7:0] s2,
                                      input logic [7:0] s3);
    filt = (s2 & s3) | (old & (s2 | s3));
  endfunction : filt

  function automatic logic [2:0] analog_mask(input logic [2:0] cfg);
    analog_mask = (cfg < `ANALOG_LIMIT) ? 3'h7 : 3'h0;
  endfunction : analog_mask

  function automatic logic [7:0] idx_of(input logic [`ADDR_W-1:0] a);
    idx_of = a[`IDX_MSB:`IDX_LSB];
  endfunction : idx_of

  function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
    logic [7:0] i;
    i = idx_of(a);
    is_mapped = (a[`ADDR_W-1:`IDX_MSB+1] == '0) && (a[`IDX_LSB-1:0] == '0) &&
                (i == `IDX_PORT_C_DATA || i == `IDX_PORT_D_DATA || i == `IDX_PORT_E_DATA ||
                 i == `IDX_PORT_C_DIR || i == `IDX_PORT_E_DIR || i == `IDX_ANALOG_CFG);
  endfunction : is_mapped

  function automatic logic [7:0] rd_mux(input logic [7:0] i, input port_pkg::state_t s);
    rd_mux = 8'h00;
    case (i)
      `IDX_PORT_C_DATA: rd_mux = s.pc_lvl;
      `IDX_PORT_D_DATA: rd_mux = s.pd_ilat;
      `IDX_PORT_E_DATA: rd_mux = {5'h00, s.pe_lvl & ~s.pe_ana};
      `IDX_PORT_C_DIR:  rd_mux = s.pc_dir;
      `IDX_PORT_E_DIR:  rd_mux = {s.input_full_flag, s.output_full_flag, s.input_overflow_flag, s.psp_en, 1'b0, s.pe_dir};
      `IDX_ANALOG_CFG:  rd_mux = {5'h00, s.pcfg};
      default:          rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // latches keep their value unless the reset is a cold one
  function automatic port_pkg::state_t rst_state(input port_pkg::state_t cur,
                                                 input logic cold);
    port_pkg::state_t s;
    s = '0;
    s.pc_lat  = cold ? `LAT_COLD8 : cur.pc_lat;
    s.pe_lat  = cold ? `LAT_COLD3 : cur.pe_lat;
    s.pd_olat = cold ? `LAT_COLD8 : cur.pd_olat;
    s.pd_ilat = cold ? `LAT_COLD8 : cur.pd_ilat;
    s.pc_dir  = `PC_DIR_RST;
    s.pe_dir  = `PE_DIR_RST;
    s.pcfg    = `PCFG_RST;
    s.pe_ana  = analog_mask(`PCFG_RST);
    s.pc_oe_n = `ALL_OFF8;
    s.pe_oe_n = 3'h7;
    s.pd_oe_n = `ALL_OFF8;
    rst_state = s;
  endfunction : rst_state

  always_comb begin
    nxt_st = st_ff;
    wd     = st_ff.wdata;

    // input synchronisers
    nxt_st.pc_s1  = pc_in;
    nxt_st.pc_s2  = st_ff.pc_s1;
    nxt_st.pc_s3  = st_ff.pc_s2;
    nxt_st.pc_lvl = filt(st_ff.pc_lvl, st_ff.pc_s2, st_ff.pc_s3);
    nxt_st.pe_s1  = pe_in;
    nxt_st.pe_s2  = st_ff.pe_s1;
    nxt_st.pe_s3  = st_ff.pe_s2;
    pe_f          = filt({5'h00, st_ff.pe_lvl}, {5'h00, st_ff.pe_s2}, {5'h00, st_ff.pe_s3});
    nxt_st.pe_lvl = pe_f[2:0];
    nxt_st.pd_s1  = pd_in;
    nxt_st.pd_s2  = st_ff.pd_s1;
    nxt_st.pd_s3  = st_ff.pd_s2;
    nxt_st.pd_lvl = filt(st_ff.pd_lvl, st_ff.pd_s2, st_ff.pd_s3);

    // write channel
    aw_take = axi_req.awvalid && st_ff.awready;
    w_take  = axi_req.wvalid && st_ff.wready;
    do_wr   = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;
    if (st_ff.bvalid && axi_req.bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (aw_take) begin
      nxt_st.aw_addr = axi_req.awaddr;
      nxt_st.aw_hold = 1'b1;
    end
    if (w_take) begin
      nxt_st.wdata  = axi_req.wdata[7:0];
      nxt_st.w_stb  = axi_req.wstrb[0];
      nxt_st.w_hold = 1'b1;
    end
    if (do_wr) begin
      nxt_st.aw_hold = 1'b0;
      nxt_st.w_hold  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = is_mapped(st_ff.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      // a write with lane 0 off is answered but changes nothing
      if (is_mapped(st_ff.aw_addr) && st_ff.w_stb) begin
        case (idx_of(st_ff.aw_addr))
          `IDX_PORT_C_DATA: nxt_st.pc_lat = wd;
          `IDX_PORT_E_DATA: nxt_st.pe_lat = wd[2:0];
          `IDX_PORT_C_DIR:  nxt_st.pc_dir = wd;
          `IDX_PORT_E_DIR: begin
            nxt_st.input_overflow_flag   = wd[`BIT_INPUT_OVERFLOW_FLAG];
            nxt_st.psp_en = wd[`BIT_PSP];
            nxt_st.pe_dir = wd[2:0];
          end
          `IDX_ANALOG_CFG: nxt_st.pcfg = wd[2:0];
          `IDX_PORT_D_DATA: begin
            nxt_st.pd_olat = wd;
            nxt_st.output_full_flag     = 1'b1;
          end
          default: nxt_st.pcfg = st_ff.pcfg;
        endcase
      end
    end
    nxt_st.awready = !nxt_st.aw_hold && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_hold && !nxt_st.bvalid;

    // read channel; data is sampled at the address handshake
    ar_take = axi_req.arvalid && st_ff.arready;
    if (st_ff.rvalid && axi_req.rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = is_mapped(axi_req.araddr) ? rd_mux(idx_of(axi_req.araddr), st_ff) : 8'h00;
      nxt_st.rresp  = is_mapped(axi_req.araddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (is_mapped(axi_req.araddr) && idx_of(axi_req.araddr) == `IDX_PORT_D_DATA) begin
        nxt_st.input_full_flag = 1'b0;
      end
    end
    nxt_st.arready = !nxt_st.rvalid;

    // parallel slave strobes, all active low, gated by chip select
    rd_act = st_ff.psp_en && !st_ff.pe_lvl[`PIN_CS] && !st_ff.pe_lvl[`PIN_RD];
    wr_act = st_ff.psp_en && !st_ff.pe_lvl[`PIN_CS] && !st_ff.pe_lvl[`PIN_WR];
    wr_end = st_ff.wr_act && !wr_act;
    nxt_st.wr_act = wr_act;
    if (wr_act) begin
      nxt_st.pd_ilat = st_ff.pd_lvl;
    end
    if (wr_end) begin
      // hardware set wins over a same-cycle software clear
      nxt_st.input_full_flag = 1'b1;
      if (st_ff.input_full_flag) begin
        nxt_st.input_overflow_flag = 1'b1;
      end
    end
    // external read keeps the output flag clear even against a new write
    if (rd_act) begin
      nxt_st.output_full_flag = 1'b0;
    end
    if (!st_ff.psp_en) begin
      nxt_st.input_full_flag = 1'b0;
      nxt_st.output_full_flag = 1'b0;
    end
    nxt_st.pd_oe_n = rd_act ? `ALL_ON8 : `ALL_OFF8;
    nxt_st.pd_out  = st_ff.pd_olat;

    // port C drive: a selected peripheral decides direction itself
    drv = (pc_periph.sel & pc_periph.oe) | (~pc_periph.sel & ~st_ff.pc_dir);
    nxt_st.pc_oe_n = ~drv;
    nxt_st.pc_out  = (pc_periph.sel & pc_periph.oe & pc_periph.out) |
                     (~(pc_periph.sel & pc_periph.oe) & st_ff.pc_lat);

    // port E drive: off when analog or used as slave strobes
    nxt_st.pe_ana  = analog_mask(nxt_st.pcfg);
    nxt_st.pe_oe_n = ~(~st_ff.pe_dir & ~st_ff.pe_ana & {3{~st_ff.psp_en}});
    nxt_st.pe_out  = st_ff.pe_lat;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_ff <= rst_state(st_ff, cold_rst);
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign axi_rsp.awready = st_ff.awready;
  assign axi_rsp.wready  = st_ff.wready;
  assign axi_rsp.bvalid  = st_ff.bvalid;
  assign axi_rsp.bresp   = st_ff.bresp;
  assign axi_rsp.arready = st_ff.arready;
  assign axi_rsp.rvalid  = st_ff.rvalid;
  assign axi_rsp.rdata   = {24'h000000, st_ff.rdata};
  assign axi_rsp.rresp   = st_ff.rresp;
  assign pc_out          = st_ff.pc_out;
  assign pc_oe_n         = st_ff.pc_oe_n;
  assign pe_out          = st_ff.pe_out;
  assign pe_oe_n         = st_ff.pe_oe_n;
  assign pe_analog_sel   = st_ff.pe_ana;
  assign pd_out          = st_ff.pd_out;
  assign pd_oe_n         = st_ff.pd_oe_n;

  // peripheral-facing levels of the shared port C pins
  assign pc_levels.timer1_clock_in          = st_ff.pc_lvl[`PIN_TIMER1_CLK];
  assign pc_levels.timer1_osc_in            = st_ff.pc_lvl[`PIN_TIMER1_OSC];
  assign pc_levels.capture_compare_pwm_2_in = st_ff.pc_lvl[`PIN_CAPTURE_COMPARE_PWM_2];
  assign pc_levels.capture_compare_pwm_1_in = st_ff.pc_lvl[`PIN_CAPTURE_COMPARE_PWM_1];
  assign pc_levels.serial_clock_in          = st_ff.pc_lvl[`PIN_SER_CLK];
  assign pc_levels.serial_data_in           = st_ff.pc_lvl[`PIN_SER_DIN];
  assign pc_levels.usart_clock_in           = st_ff.pc_lvl[`PIN_USART_CLK];
  assign pc_levels.usart_data_in            = st_ff.pc_lvl[`PIN_USART_DATA];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  dir_reset_a: assert property (@(posedge mclk) disable iff (1'b0)
    !rstn |=> st_ff.pc_dir == `PC_DIR_RST && pc_oe_n == `ALL_OFF8)
    else $error("port C directions not input after reset");

  port_e_direction_and_slave_status_reset_a: assert property (@(posedge mclk) disable iff (1'b0)
    !rstn |=> st_ff.pe_dir == `PE_DIR_RST && !st_ff.psp_en && !st_ff.input_full_flag && !st_ff.input_overflow_flag
              && st_ff.pcfg == `PCFG_RST)
    else $error("port E direction register reset wrong");

  input_release_a: assert property (
    ce && pc_periph.sel == 8'h00 |=> pc_oe_n == $past(st_ff.pc_dir))
    else $error("port C driver state does not follow direction");

  latch_drive_a: assert property (
    rstn && ce && pc_periph.sel == 8'h00 |=> pc_out == $past(st_ff.pc_lat))
    else $error("port C pin value not from latch");

  periph_dir_a: assert property (
    ce |=> (pc_oe_n & $past(pc_periph.sel)) == $past(pc_periph.sel & ~pc_periph.oe))
    else $error("peripheral direction override lost");

  oe_select_a: assert property (
    ce |=> (~pc_oe_n & $past(~pc_periph.sel & pc_periph.oe))
           == $past(~st_ff.pc_dir & ~pc_periph.sel & pc_periph.oe))
    else $error("peripheral enable acted without select");

  slave_read_a: assert property (
    ce && rd_act |=> pd_oe_n == `ALL_ON8 && pd_out == $past(st_ff.pd_olat) && !st_ff.output_full_flag)
    else $error("slave read did not drive port D");

  slave_write_a: assert property (
    ce && wr_end |=> st_ff.input_full_flag && (st_ff.input_overflow_flag || !$past(st_ff.input_full_flag)))
    else $error("slave write end did not set flags");

  cs_gate_a: assert property (
    ce && st_ff.pe_lvl[`PIN_CS] |=> pd_oe_n == `ALL_OFF8 && !st_ff.wr_act)
    else $error("strobe acted while not selected");

  pe_drive_a: assert property (
    ce |=> (~pe_oe_n & $past(st_ff.pe_ana | st_ff.pe_dir | {3{st_ff.psp_en}})) == 3'h0)
    else $error("port E driven while input or analog");

  flags_off_a: assert property (
    ce && !st_ff.psp_en |=> !st_ff.input_full_flag && !st_ff.output_full_flag)
    else $error("full flags set outside slave mode");

  sync_agree_a: assert property (
    ce && st_ff.pc_s2 == st_ff.pc_s3 |=> st_ff.pc_lvl == $past(st_ff.pc_s3))
    else $error("synchronised level not updated");

  bresp_hold_a: assert property (
    st_ff.bvalid && !(ce && axi_req.bready) |=> st_ff.bvalid && $stable(st_ff.bresp))
    else $error("write response dropped early");

  rdata_hold_a: assert property (
    st_ff.rvalid && !(ce && axi_req.rready) |=> st_ff.rvalid && $stable(st_ff.rdata) && $stable(st_ff.rresp))
    else $error("read response dropped early");

  write_stall_a: assert property (
    st_ff.bvalid |-> !st_ff.awready && !st_ff.wready)
    else $error("write channels open while response pending");

  read_stall_a: assert property (
    st_ff.rvalid |-> !st_ff.arready)
    else $error("read address open while data pending");

  pe_latch_a: assert property (
    rstn && ce |=> pe_out == $past(st_ff.pe_lat))
    else $error("port E pin value not from latch");

  pd_idle_a: assert property (
    ce && !st_ff.psp_en |=> pd_oe_n == `ALL_OFF8)
    else $error("port D driven outside slave mode");

  analog_decode_a: assert property (
    pe_analog_sel == ((st_ff.pcfg < `ANALOG_LIMIT) ? 3'h7 : 3'h0))
    else $error("analog select does not follow config field");

  cdata_write_a: assert property (
    ce && do_wr && st_ff.w_stb && st_ff.aw_addr == {2'h0, `IDX_PORT_C_DATA, 2'h0}
    |=> st_ff.pc_lat == $past(st_ff.wdata))
    else $error("port C latch write lost");

  cdir_write_a: assert property (
    ce && do_wr && st_ff.w_stb && st_ff.aw_addr == {2'h0, `IDX_PORT_C_DIR, 2'h0}
    |=> st_ff.pc_dir == $past(st_ff.wdata))
    else $error("port C direction write lost");

  obf_set_a: assert property (
    ce && do_wr && st_ff.w_stb && st_ff.psp_en && !rd_act && st_ff.aw_addr == {2'h0, `IDX_PORT_D_DATA, 2'h0}
    |=> st_ff.output_full_flag)
    else $error("output full flag not set by port D write");

  slave_latch_a: assert property (
    ce && wr_act |=> st_ff.pd_ilat == $past(st_ff.pd_lvl))
    else $error("port D input latch not following pins");

  pe_level_a: assert property (
    ce && st_ff.pe_s2 == st_ff.pe_s3 |=> st_ff.pe_lvl == $past(st_ff.pe_s3))
    else $error("port E synchronised level not updated");

  slave_read_c:  cover property (ce && rd_act ##1 !rd_act);
  overflow_c:    cover property (ce && wr_end && st_ff.input_full_flag);
  periph_out_c:  cover property (ce && (pc_periph.sel & pc_periph.oe) != 8'h00);
  bus_write_c:   cover property (do_wr && ce ##1 st_ff.bvalid);
  slave_write_c: cover property (ce && wr_act ##1 !wr_act);

endmodule : port_c_e_pin_control
`default_nettype wire

// ==== tb/ext_bus_model.sv ====
// Purpose: pin loads and external parallel bus master facing the port block
// Assumes: port E strobes active low, one transfer per go pulse
// Notes: released port D floats to the inverse of the last data
`timescale 1ns/1ps
`default_nettype none
module ext_bus_model (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [2:0] pat,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] hold,
  input  wire logic [7:0] pc_ext,
  input  wire logic [7:0] pc_out,
  input  wire logic [7:0] pc_oe_n,
  input  wire logic [2:0] pe_out,
  input  wire logic [2:0] pe_oe_n,
  input  wire logic [7:0] pd_out,
  input  wire logic [7:0] pd_oe_n,
  output logic      [7:0] pc_in,
  output logic      [2:0] pe_in,
  output logic      [7:0] pd_in,
  output logic      [7:0] rdata,
  output logic            done
);
  logic [2:0] strb;
  logic       drv;
  logic [7:0] last;

  assign pc_in = (pc_out & ~pc_oe_n) | (pc_ext & pc_oe_n);
  assign pe_in = (pe_out & ~pe_oe_n) | (strb & pe_oe_n);
  assign pd_in = (pd_out & ~pd_oe_n) | ((drv ? last : ~last) & pd_oe_n);

  initial begin
    strb  = 3'h7;
    drv   = 1'b0;
    last  = 8'h00;
    done  = 1'b0;
    rdata = 8'h00;
    forever begin
      @(posedge mclk);
      done <= 1'b0;
      if (go) begin
        strb <= pat;
        drv  <= ~pat[1];
        last <= wdata;
        repeat (hold) @(posedge mclk);
        rdata <= pd_in;
        strb  <= 3'h7;
        // data held two cycles past the strobe
        repeat (2) @(posedge mclk);
        drv  <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule : ext_bus_model
`default_nettype wire

// ==== tb/port_c_e_pin_control_tb.sv ====
// Purpose: register and pin scenarios for the port C / port E block
// Assumes: index times four is the byte address
// Notes: pin levels need about five cycles to settle through the filters
`timescale 1ns/1ps
`default_nettype none
`include "port_consts.svh"
module port_c_e_pin_control_tb;
  logic                  mclk, rstn, cold_rst, ce, go, done;
  port_pkg::axi_req_t    req;
  port_pkg::axi_rsp_t    rsp;
  port_pkg::periph_req_t periph;
  port_pkg::periph_lvl_t lvls;
  logic [7:0]            pc_in, pc_out, pc_oe_n, pd_in, pd_out, pd_oe_n, pc_ext, bwd, brd, rd;
  logic [2:0]            pe_in, pe_out, pe_oe_n, pe_ana, pat;
  int                    failures, checks;

  port_c_e_pin_control u_dut (.mclk(mclk), .rstn(rstn), .cold_rst(cold_rst), .ce(ce),
    .axi_req(req), .axi_rsp(rsp), .pc_periph(periph), .pc_levels(lvls), .pc_in(pc_in),
    .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pe_in(pe_in), .pe_out(pe_out), .pe_oe_n(pe_oe_n),
    .pe_analog_sel(pe_ana), .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n));

  ext_bus_model u_ext (.mclk(mclk), .go(go), .pat(pat), .wdata(bwd), .hold(8'h08),
    .pc_ext(pc_ext), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pe_out(pe_out), .pe_oe_n(pe_oe_n),
    .pd_out(pd_out), .pd_oe_n(pd_oe_n), .pc_in(pc_in), .pe_in(pe_in), .pd_in(pd_in),
    .rdata(brd), .done(done));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr  <= {2'h0, idx, 2'h0};
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'hFFFFFF, d};
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 50);
    chk("bvalid", rsp.bvalid, 1'b1);
    chk("bresp", rsp.bresp, er);
    req.bready <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rdr(input logic [7:0] idx, output logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr  <= {2'h0, idx, 2'h0};
    req.rready  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 50);
    d = rsp.rdata[7:0];
    chk("rvalid", rsp.rvalid, 1'b1);
    chk("rresp", rsp.rresp, er);
    chk("rdata high", rsp.rdata[31:8], 24'h0);
    req.rready <= 1'b0;
    @(posedge mclk);
  endtask : rdr

  task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    rdr(idx, v, `RESP_OKAY);
    chk(nm, v, exp);
  endtask : rc

  task automatic xfer(input logic [2:0] p, input logic [7:0] d);
    int n;
    n = 0;
    pat <= p;
    bwd <= d;
    go  <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    while (!done && n < 100) begin
      @(posedge mclk);
      n++;
    end
    chk("done", done, 1'b1);
  endtask : xfer

  task automatic do_reset(input logic cold);
    rstn     <= 1'b0;
    cold_rst <= cold;
    cyc(12);
    rstn <= 1'b1;
    cyc(2);
  endtask : do_reset

  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // generous: the whole run is under two thousand cycles
  initial begin
    #100us;
    failures++;
    test_done;
  end

  initial begin
    failures = 0;
    checks   = 0;
    rstn     = 1'b0;
    cold_rst = 1'b1;
    ce       = 1'b1;
    req      = '0;
    periph   = '0;
    pc_ext   = 8'h3C;
    go       = 1'b0;
    pat      = 3'h7;
    bwd      = 8'h00;
    @(posedge mclk);
    do_reset(1'b1);
    chk("pc_oe_n rst", pc_oe_n, 8'hFF);
    chk("pe rst", {pe_oe_n, pe_ana}, 6'h3F);
    chk("pc_out cold", pc_out, `LAT_COLD8);
    rc("pc_dir rst", `IDX_PORT_C_DIR, `PC_DIR_RST);
    rc("pe_dir rst", `IDX_PORT_E_DIR, 8'h07);
    rc("pcfg rst", `IDX_ANALOG_CFG, 8'h00);
    rdr(8'h05, rd, `RESP_SLVERR);
    chk("unmapped", rd, 8'h00);
    wr(8'h05, 8'h00, 4'h1, `RESP_SLVERR);
    wr(`IDX_PORT_C_DIR, 8'h00, 4'h0, `RESP_OKAY);
    rc("pc_dir no strobe", `IDX_PORT_C_DIR, 8'hFF);
    $display("reset test done");
    wr(`IDX_PORT_C_DATA, 8'hA5, 4'h1, `RESP_OKAY);
    cyc(2);
    chk("pc_oe_n input", pc_oe_n, 8'hFF);
    wr(`IDX_PORT_C_DIR, 8'h0F, 4'h1, `RESP_OKAY);
    cyc(2);
    chk("pc_oe_n dir", pc_oe_n, 8'h0F);
    chk("pc_out latch", pc_out, 8'hA5);
    cyc(6);
    rc("pc level", `IDX_PORT_C_DATA, 8'hAC);
    periph <= '{sel: 8'h30, oe: 8'h11, out: 8'hFF};
    cyc(8);
    chk("pc_oe_n periph", pc_oe_n, 8'h2F);
    chk("pc_out periph", pc_out, 8'hB5);
    chk("levels", lvls, 8'h1D);
    periph <= '0;
    $display("port c test done");
    wr(`IDX_ANALOG_CFG, 8'h04, 4'h1, `RESP_OKAY);
    wr(`IDX_PORT_E_DATA, 8'hFD, 4'h1, `RESP_OKAY);
    wr(`IDX_PORT_E_DIR, 8'h00, 4'h1, `RESP_OKAY);
    cyc(8);
    chk("pe digital", {pe_ana, pe_oe_n, pe_out}, 9'h005);
    rc("pe level", `IDX_PORT_E_DATA, 8'h05);
    wr(`IDX_ANALOG_CFG, 8'h03, 4'h1, `RESP_OKAY);
    cyc(2);
    chk("pe analog", {pe_ana, pe_oe_n}, 6'h3F);
    rc("pe analog rd", `IDX_PORT_E_DATA, 8'h00);
    rc("pcfg rd", `IDX_ANALOG_CFG, 8'h03);
    $display("port e test done");
    wr(`IDX_ANALOG_CFG, 8'h07, 4'h1, `RESP_OKAY);
    wr(`IDX_PORT_E_DIR, 8'h17, 4'h1, `RESP_OKAY);
    wr(`IDX_PORT_D_DATA, 8'h5A, 4'h1, `RESP_OKAY);
    rc("obf set", `IDX_PORT_E_DIR, 8'h57);
    xfer(3'b010, 8'h00);
    chk("slave read", brd, 8'h5A);
    cyc(8);
    chk("pd released", pd_oe_n, 8'hFF);
    rc("obf clear", `IDX_PORT_E_DIR, 8'h17);
    xfer(3'b001, 8'h3C);
    cyc(8);
    rc("ibf set", `IDX_PORT_E_DIR, 8'h97);
    xfer(3'b101, 8'h99);
    xfer(3'b110, 8'h00);
    chk("no select read", brd, 8'hFF);
    cyc(8);
    rc("no select write", `IDX_PORT_E_DIR, 8'h97);
    xfer(3'b001, 8'hC3);
    cyc(8);
    rc("overflow", `IDX_PORT_E_DIR, 8'hB7);
    rc("pd latch", `IDX_PORT_D_DATA, 8'hC3);
    rc("ibf clear", `IDX_PORT_E_DIR, 8'h37);
    wr(`IDX_PORT_D_DATA, 8'h11, 4'h1, `RESP_OKAY);
    wr(`IDX_PORT_E_DIR, 8'h27, 4'h1, `RESP_OKAY);
    cyc(2);
    rc("slave off", `IDX_PORT_E_DIR, 8'h27);
    $display("slave test done");
    do_reset(1'b0);
    chk("warm pc_out", pc_out, 8'hA5);
    chk("warm pc_oe_n", pc_oe_n, 8'hFF);
    rc("warm pe_dir", `IDX_PORT_E_DIR, 8'h07);
    $display("warm reset test done");
    ce     <= 1'b0;
    periph <= '{sel: 8'hFF, oe: 8'hFF, out: 8'h00};
    cyc(4);
    chk("ce freeze", pc_oe_n, 8'hFF);
    ce <= 1'b1;
    cyc(2);
    chk("ce run", pc_oe_n, 8'h00);
    $display("clock enable test done");
    test_done;
  end
endmodule : port_c_e_pin_control_tb
`default_nettype wire
